// ==== logic/rrm_defs.svh ====
`ifndef RRM_DEFS_SVH
`define RRM_DEFS_SVH

`define RRM_CORE_HZ 25000000
`define RRM_MGMT_HZ 781250
`define RRM_MGMT_DIV (`RRM_CORE_HZ / `RRM_MGMT_HZ)
`define RRM_MGMT_HALF (`RRM_MGMT_DIV / 2)
`define RRM_BANK_BYTES 512
`define RRM_BANK_WORDS (`RRM_BANK_BYTES / 4)
`define RRM_AW 11
`define RRM_WIDX_W 7
`define RRM_CRC_INIT 16'hFFFF
`define RRM_CRC_POLY 16'h1021
`define RRM_MGMT_FRAME 64
`define RRM_MGMT_TA_BIT 46
`define RRM_PREAMBLE_NIB 4'h5
`define RRM_SFD_NIB 4'hD
`define RRM_WAIT_CYC 3

`endif

// ==== logic/rrm_pkg.sv ====
package rrm_pkg;
  typedef enum logic [1:0] {
    RRM_TX_IDLE = 2'b00,
    RRM_TX_PRE = 2'b01,
    RRM_TX_DATA = 2'b10,
    RRM_TX_CRC = 2'b11
  } rrm_tx_state_t;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
  } rrm_host_strobe_t;

  typedef struct packed {
    logic [3:0] nib;
    logic dv;
    logic er;
  } rrm_mii_rx_t;
endpackage

// ==== logic/rrm_sync2.sv ====
`timescale 1ns/1ns
module rrm_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule

// ==== logic/rrm_master_port.sv ====
`timescale 1ns/1ns
`include "rrm_defs.svh"
// Overview of operation
// R01: Board ties both mode pins low for master; other combinations are unused.
// R02: Width pin low uses D[15:0], A[10:1]; high uses D[31:0], A[10:2].
// R03: Address is 11 bits; A0 ignored in 16-bit, A1 and A0 in 32-bit.
// R04: Transmit nibble is driven synchronous to the 25 MHz PHY transmit clock.
// R05: Transmit enable marks valid nibbles; both low during reset.
// R06: Receive nibbles count as frame data only while receive valid is high.
// R07: Receive error during a frame marks that frame as erroneous.
// R08: Management clock runs at 781.25 kHz and is low during reset.
// R09: Management data line is clocked by management clock, reads and writes, released in reset.
// R10: Host uses low-active select, read and write; device answers only when selected.
// R11: Wait output low while an access is extended, high during reset.
// R12: Data bus released in reset, driven only on reads; upper half unused in 16-bit.
// R13: Two 512-byte banks each for transmit and receive, swapped between host and link.
// R14: Frames carry a CCITT 16-bit CRC, checked on reception.
// R15: Master transmits command frames cyclically and receives responses, full duplex.
// R16: Core logic runs from the 25 MHz clock shared with the PHY.
// R17: Reset state is held while the low-active hardware reset is low.
// R18: Host strobes and PHY clock domains are synchronised into the core domain.
// R19: Management clock is the core clock divided by 32.
module rrm_master_port
  import rrm_pkg::*;
(
  input wire logic clock,
  input wire logic hw_reset_n,
  input wire logic op_select_hi,
  input wire logic op_select_lo,
  input wire logic host_width_select,
  input wire logic [10:0] host_addr,
  input wire logic [31:0] host_data_in,
  output logic [31:0] host_data_out,
  output logic [31:0] host_data_oe,
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  output logic host_stall_n,
  input wire logic tx_clock,
  output logic [3:0] tx_nibble,
  output logic tx_enable,
  input wire logic rx_clock,
  input wire logic [3:0] rx_nibble,
  input wire logic rx_valid,
  input wire logic rx_error,
  output logic mgmt_clock,
  input wire logic mgmt_data_in,
  output logic mgmt_data_out,
  output logic mgmt_data_oe,
  input wire logic [31:0] mgmt_command,
  input wire logic mgmt_start,
  output logic [15:0] mgmt_read_data,
  output logic mgmt_busy,
  output logic master_mode,
  output logic rx_frame_bad
);
  // Reset pin passes two flops; entry and release both lag the pin by two edges (R17)
  logic reset;
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clock) begin
    rst_meta_reg <= ~hw_reset_n; // R16 R17
    rst_sync_reg <= rst_meta_reg;
  end
  assign reset = rst_sync_reg;

  // Link-side resets derived in their own domains
  logic tx_rst_meta_reg, tx_reset;
  logic rx_rst_meta_reg, rx_reset;
  always_ff @(posedge tx_clock) begin
    tx_rst_meta_reg <= reset;
    tx_reset <= tx_rst_meta_reg;
  end
  always_ff @(posedge rx_clock) begin
    rx_rst_meta_reg <= reset;
    rx_reset <= rx_rst_meta_reg;
  end

  logic [1:0] mode_s;
  rrm_sync2 #(.W(2)) u_mode_sync (.clock(clock), .reset(reset),
    .din({op_select_hi, op_select_lo}), .dout(mode_s));
  assign master_mode = (mode_s == 2'b00); // R01

  // Host interface
  logic [2:0] strobe_s;
  rrm_host_strobe_t hs;
  logic width_s;
  rrm_sync2 #(.W(4)) u_host_sync (.clock(clock), .reset(reset),
    .din({~host_select_n, ~host_read_n, ~host_write_n, host_width_select}),
    .dout({strobe_s, width_s})); // R18
  assign hs = strobe_s;

  logic [31:0] tx_mem [0:2*`RRM_BANK_WORDS-1];
  logic [31:0] rx_mem [0:2*`RRM_BANK_WORDS-1];
  logic host_bank_reg;
  logic wr_done_reg;
  logic [1:0] wait_cnt_reg;
  logic rd_active_reg;
  logic [`RRM_WIDX_W-1:0] widx;
  logic half_sel;

  // 16-bit mode drops A0 and uses A1 as half select; 32-bit drops A1:A0
  assign widx = host_addr[8:2]; // R02 R03
  assign half_sel = ~width_s & host_addr[1]; // R03

  always_ff @(posedge clock) begin
    if (reset) begin
      wait_cnt_reg <= '0;
      wr_done_reg <= 1'b0;
      rd_active_reg <= 1'b0;
    end else if (hs.sel && (hs.rd || hs.wr)) begin // R10
      if (wait_cnt_reg != 2'(`RRM_WAIT_CYC)) begin
        wait_cnt_reg <= wait_cnt_reg + 2'd1;
      end
      rd_active_reg <= hs.rd;
      if (hs.wr && !wr_done_reg && wait_cnt_reg == 2'(`RRM_WAIT_CYC)) begin
        wr_done_reg <= 1'b1;
      end
    end else begin
      wait_cnt_reg <= '0;
      wr_done_reg <= 1'b0;
      rd_active_reg <= 1'b0;
    end
  end

  // Stall until the synchronised strobes and memory read have settled
  assign host_stall_n = reset ? 1'b1 :
    ~(~host_select_n & (~host_read_n | ~host_write_n) &
      (wait_cnt_reg != 2'(`RRM_WAIT_CYC))); // R11

  logic host_wr_pulse;
  assign host_wr_pulse = hs.sel && hs.wr && !wr_done_reg &&
                         wait_cnt_reg == 2'(`RRM_WAIT_CYC);
  // Upper address half picks receive bank; writes go to transmit bank
  always_ff @(posedge clock) begin
    if (host_wr_pulse && !host_addr[10]) begin
      if (width_s) begin
        tx_mem[{host_bank_reg, widx}] <= host_data_in;
      end else if (half_sel) begin
        tx_mem[{host_bank_reg, widx}][31:16] <= host_data_in[15:0];
      end else begin
        tx_mem[{host_bank_reg, widx}][15:0] <= host_data_in[15:0];
      end
    end
  end

  logic [31:0] rd_word;
  // Receiver fills the opposite bank, which becomes the host bank at the swap
  assign rd_word = host_addr[10] ? rx_mem[{host_bank_reg, widx}]
                                 : tx_mem[{host_bank_reg, widx}];
  always_ff @(posedge clock) begin
    if (reset) begin
      host_data_out <= '0;
      host_data_oe <= '0;
    end else if (hs.sel && hs.rd) begin // R12
      host_data_out <= width_s ? rd_word :
        {16'h0000, half_sel ? rd_word[31:16] : rd_word[15:0]};
      host_data_oe <= width_s ? 32'hFFFFFFFF : 32'h0000FFFF; // R12
    end else begin
      host_data_oe <= '0;
    end
  end

  // Cycle toggle from the transmitter swaps the banks (R13, R15)
  logic tx_cycle_tgl_reg;
  logic [2:0] cyc_s;
  always_ff @(posedge clock) begin
    if (reset) begin
      cyc_s <= '0;
      host_bank_reg <= 1'b0;
    end else begin
      cyc_s <= {cyc_s[1:0], tx_cycle_tgl_reg}; // R18
      if (cyc_s[2] ^ cyc_s[1]) begin
        host_bank_reg <= ~host_bank_reg; // R13
      end
    end
  end

  // Transmit domain
  logic bank_t_meta, bank_t;
  always_ff @(posedge tx_clock) begin
    bank_t_meta <= host_bank_reg;
    bank_t <= bank_t_meta;
  end

  function automatic logic [15:0] crc_nib(input logic [15:0] c, input logic [3:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `RRM_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  rrm_tx_state_t tx_state_reg;
  logic [9:0] tx_cnt_reg;
  logic [15:0] tx_crc_reg;
  logic [31:0] tx_word;
  logic [3:0] tx_nib_sel;
  assign tx_word = tx_mem[{~bank_t, tx_cnt_reg[9:3]}];
  assign tx_nib_sel = tx_word[{tx_cnt_reg[2:0], 2'b00} +: 4];

  // CRC goes out MSB first on the wire, so bit 0 of each nibble carries the higher bit
  logic [3:0] crc_out_nib;
  for (genvar i = 0; i < 4; i++) begin : g_crc_nib
    assign crc_out_nib[i] = tx_crc_reg[15 - 4 * int'(tx_cnt_reg[1:0]) - i];
  end

  always_ff @(posedge tx_clock) begin // R04
    if (tx_reset) begin
      tx_state_reg <= RRM_TX_IDLE;
      tx_cnt_reg <= '0;
      tx_nibble <= 4'h0; // R05
      tx_enable <= 1'b0; // R05
      tx_crc_reg <= `RRM_CRC_INIT;
      tx_cycle_tgl_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        RRM_TX_IDLE: begin
          tx_enable <= 1'b0;
          tx_nibble <= 4'h0;
          tx_cnt_reg <= tx_cnt_reg + 10'd1;
          if (tx_cnt_reg == 10'h3FF) begin // R15
            tx_state_reg <= RRM_TX_PRE;
            tx_cnt_reg <= '0;
          end
        end
        RRM_TX_PRE: begin
          tx_enable <= 1'b1; // R05
          tx_cnt_reg <= tx_cnt_reg + 10'd1;
          tx_nibble <= (tx_cnt_reg == 10'd15) ? `RRM_SFD_NIB : `RRM_PREAMBLE_NIB;
          if (tx_cnt_reg == 10'd15) begin
            tx_state_reg <= RRM_TX_DATA;
            tx_cnt_reg <= '0;
            tx_crc_reg <= `RRM_CRC_INIT;
          end
        end
        RRM_TX_DATA: begin
          tx_nibble <= tx_nib_sel;
          tx_crc_reg <= crc_nib(tx_crc_reg, tx_nib_sel); // R14
          tx_cnt_reg <= tx_cnt_reg + 10'd1;
          if (tx_cnt_reg == 10'h3FF) begin
            tx_state_reg <= RRM_TX_CRC;
            tx_cnt_reg <= '0;
          end
        end
        default: begin
          tx_nibble <= crc_out_nib; // R14
          tx_cnt_reg <= tx_cnt_reg + 10'd1;
          if (tx_cnt_reg == 10'd3) begin
            tx_state_reg <= RRM_TX_IDLE;
            tx_cnt_reg <= '0;
            tx_cycle_tgl_reg <= ~tx_cycle_tgl_reg;
          end
        end
      endcase
    end
  end

  // Receive domain
  rrm_mii_rx_t rx_in_reg;
  logic bank_r_meta, bank_r;
  logic [9:0] rx_cnt_reg;
  logic [15:0] rx_crc_reg;
  logic rx_err_reg, rx_in_frame_reg, rx_active_reg;
  logic rx_bad_tgl_reg, rx_good_tgl_reg;
  logic [31:0] rx_shift_reg;
  always_ff @(posedge rx_clock) begin
    bank_r_meta <= host_bank_reg;
    bank_r <= bank_r_meta;
    rx_in_reg <= '{nib: rx_nibble, dv: rx_valid, er: rx_error};
  end

  always_ff @(posedge rx_clock) begin
    if (rx_reset) begin
      rx_cnt_reg <= '0;
      rx_crc_reg <= `RRM_CRC_INIT;
      rx_err_reg <= 1'b0;
      rx_in_frame_reg <= 1'b0;
      rx_active_reg <= 1'b0;
      rx_bad_tgl_reg <= 1'b0;
      rx_good_tgl_reg <= 1'b0;
      rx_shift_reg <= '0;
    end else if (rx_in_reg.dv) begin // R06
      rx_active_reg <= 1'b1;
      if (rx_in_reg.er) begin
        rx_err_reg <= 1'b1; // R07
      end
      // Preamble is skipped; data and CRC start after the delimiter nibble
      if (rx_in_frame_reg) begin
        rx_crc_reg <= crc_nib(rx_crc_reg, rx_in_reg.nib); // R14
        rx_shift_reg <= {rx_in_reg.nib, rx_shift_reg[31:4]};
        rx_cnt_reg <= rx_cnt_reg + 10'd1;
        if (rx_cnt_reg[2:0] == 3'd7) begin
          rx_mem[{~bank_r, rx_cnt_reg[9:3]}] <= {rx_in_reg.nib, rx_shift_reg[31:4]}; // R13
        end
      end else if (rx_in_reg.nib == `RRM_SFD_NIB) begin
        rx_in_frame_reg <= 1'b1;
      end
    end else if (rx_active_reg) begin
      // Residue of zero means data and trailing CRC agree
      if (rx_err_reg || !rx_in_frame_reg || rx_crc_reg != 16'h0000) begin // R14 R07
        rx_bad_tgl_reg <= ~rx_bad_tgl_reg;
      end else begin
        rx_good_tgl_reg <= ~rx_good_tgl_reg;
      end
      rx_in_frame_reg <= 1'b0;
      rx_active_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_crc_reg <= `RRM_CRC_INIT;
    end
  end

  logic [2:0] bad_s, good_s;
  always_ff @(posedge clock) begin
    if (reset) begin
      bad_s <= '0;
      good_s <= '0;
      rx_frame_bad <= 1'b0;
    end else begin
      bad_s <= {bad_s[1:0], rx_bad_tgl_reg}; // R18
      good_s <= {good_s[1:0], rx_good_tgl_reg};
      if (bad_s[2] ^ bad_s[1]) begin
        rx_frame_bad <= 1'b1;
      end else if (good_s[2] ^ good_s[1]) begin
        rx_frame_bad <= 1'b0;
      end
    end
  end

  // Management port: divide by 32, shift 64-bit frame MSB first
  logic [4:0] mdiv_reg;
  logic [6:0] mbit_reg;
  logic [63:0] mshift_reg;
  logic mdi_meta, mdi_s;
  always_ff @(posedge clock) begin
    mdi_meta <= mgmt_data_in;
    mdi_s <= mdi_meta; // R18
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mdiv_reg <= '0;
      mgmt_clock <= 1'b0; // R08
      mgmt_busy <= 1'b0;
      mbit_reg <= '0;
      mshift_reg <= '0;
      mgmt_data_out <= 1'b1;
      mgmt_data_oe <= 1'b0; // R09
      mgmt_read_data <= '0;
    end else begin
      mdiv_reg <= mdiv_reg + 5'd1; // R19
      if (mdiv_reg == 5'(`RRM_MGMT_HALF - 1)) begin
        mgmt_clock <= 1'b1; // R08
        if (mgmt_busy && mgmt_data_oe == 1'b0) begin
          mgmt_read_data <= {mgmt_read_data[14:0], mdi_s}; // R09
        end
      end else if (mdiv_reg == 5'(`RRM_MGMT_DIV - 1)) begin
        mgmt_clock <= 1'b0;
        if (mgmt_busy) begin
          mgmt_data_out <= mshift_reg[63];
          mshift_reg <= {mshift_reg[62:0], 1'b1};
          mbit_reg <= mbit_reg + 7'd1;
          // Read command releases the line from turnaround on
          mgmt_data_oe <= !(mgmt_command[29:28] == 2'b10 &&
            mbit_reg >= 7'(`RRM_MGMT_TA_BIT));
          if (mbit_reg == 7'(`RRM_MGMT_FRAME)) begin
            mgmt_busy <= 1'b0;
            mgmt_data_oe <= 1'b0;
          end
        end else if (mgmt_start) begin
          mgmt_busy <= 1'b1;
          mbit_reg <= '0;
          mshift_reg <= {32'hFFFFFFFF, mgmt_command};
          mgmt_read_data <= '0;
        end
      end
    end
  end
endmodule

// ==== verification/rrm_master_port_monitor.sv ====
`timescale 1ns/1ns
module rrm_master_port_monitor (
  input wire logic clock,
  input wire logic hw_reset_n,
  input wire logic op_select_hi,
  input wire logic op_select_lo,
  input wire logic host_width_select,
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic [31:0] host_data_oe,
  input wire logic host_stall_n,
  input wire logic tx_clock,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_enable,
  input wire logic mgmt_clock,
  input wire logic mgmt_data_oe,
  input wire logic master_mode
);
  logic [3:0] st_cnt = 4'h0;
  logic [4:0] half_cnt;
  logic mc_seen;
  logic [2:0] idle_cnt;
  logic [10:0] tx_len;
  default clocking @(posedge clock); endclocking
  default disable iff (!hw_reset_n);
  // Age of the present reset level, so reset checks skip the first edges
  always_ff @(posedge clock) begin
    if ($changed(hw_reset_n)) st_cnt <= 4'h0;
    else if (st_cnt != 4'hF) st_cnt <= st_cnt + 4'h1;
  end
  always_ff @(posedge clock) begin
    if (!hw_reset_n) begin
      half_cnt <= 5'h00;
      mc_seen <= 1'b0;
      idle_cnt <= 3'h7;
    end else begin
      half_cnt <= $changed(mgmt_clock) ? 5'h00 : half_cnt + 5'h01;
      if ($changed(mgmt_clock)) mc_seen <= 1'b1;
      if (!host_select_n && !host_read_n) idle_cnt <= 3'h0;
      else if (idle_cnt != 3'h7) idle_cnt <= idle_cnt + 3'h1;
    end
  end
  always_ff @(posedge tx_clock) begin
    if (!hw_reset_n || !tx_enable) tx_len <= 11'h000;
    else tx_len <= tx_len + 11'h001;
  end
  rst_link_a: assert property (disable iff (1'b0)
    !hw_reset_n && st_cnt > 4'h9 |-> !tx_enable && tx_nibble == 4'h0 && !mgmt_clock)
    else $error("link active in reset");
  rst_bus_a: assert property (disable iff (1'b0)
    !hw_reset_n && st_cnt > 4'h9 |-> host_data_oe == 32'h0 && !mgmt_data_oe && host_stall_n)
    else $error("bus driven in reset");
  mdc_half_a: assert property (mc_seen && $changed(mgmt_clock) |-> half_cnt == 5'h0F)
    else $error("mgmt clock period");
  read_drive_a: assert property (host_data_oe != 32'h0 |-> idle_cnt < 3'h6)
    else $error("data driven off read");
  upper_idle_a: assert property (!host_width_select && !$past(host_width_select, 4) |->
    host_data_oe[31:16] == 16'h0000) else $error("upper half driven");
  stall_end_a: assert property (!host_stall_n |-> ##[1:8] host_stall_n)
    else $error("wait too long");
  stall_sel_a: assert property (host_select_n [*5] |-> host_stall_n)
    else $error("wait unselected");
  mode_strap_a: assert property (st_cnt == 4'hF && !op_select_hi && !op_select_lo |->
    master_mode) else $error("not master");
  tx_len_a: assert property (@(posedge tx_clock) disable iff (!hw_reset_n)
    $fell(tx_enable) |-> tx_len == 11'h414) else $error("frame length");
  tx_pre_a: assert property (@(posedge tx_clock) disable iff (!hw_reset_n)
    $rose(tx_enable) |-> tx_nibble == 4'h5 ##15 tx_nibble == 4'hD) else $error("preamble");
  cover property (@(posedge tx_clock) $fell(tx_enable));
  cover property (host_data_oe[15:0] == 16'hFFFF && !host_width_select);
  cover property ($fell(mgmt_data_oe));
endmodule

// ==== verification/rrm_phy_model.sv ====
`timescale 1ns/1ns
module rrm_phy_model #(
  parameter logic [15:0] READ_VAL = 16'hA5C3
) (
  output logic link_clock,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_enable,
  output logic [3:0] rx_nibble,
  output logic rx_valid,
  output logic rx_error,
  input wire logic [1:0] err_mode,
  input wire logic mgmt_clock,
  input wire logic mgmt_data_out,
  input wire logic mgmt_data_oe,
  output logic mgmt_data_in
);
  logic [3:0] frame [0:1043];
  logic [31:0] mdio_seen;
  logic [5:0] bit_cnt = 6'h00;
  logic phy_oe = 1'b0;
  logic phy_out = 1'b1;
  int idx = 0;
  initial link_clock = 1'b0;
  initial rx_nibble = 4'h0;
  always #3 link_clock = ~link_clock;
  // Ring loopback one clock late; idle nibbles toggle so stale data never looks valid
  always @(posedge link_clock) begin
    idx <= tx_enable ? idx + 1 : 0;
    if (tx_enable) frame[idx] <= tx_nibble;
    rx_valid <= tx_enable;
    rx_nibble <= tx_enable ? tx_nibble ^ {3'h0, err_mode == 2'h2 && idx == 400} : ~rx_nibble;
    rx_error <= tx_enable && err_mode == 2'h1 && idx == 300;
  end
  // Pull-up holds the line high whenever nobody drives it
  assign mgmt_data_in = mgmt_data_oe ? mgmt_data_out : (phy_oe ? phy_out : 1'b1);
  always @(posedge mgmt_clock) begin
    if (mgmt_data_oe || bit_cnt != 6'h00) bit_cnt <= bit_cnt + 6'h01;
    if (bit_cnt >= 6'h20) mdio_seen <= {mdio_seen[30:0], mgmt_data_in};
  end
  // Answers only read frames: turnaround zero, then data MSB first
  always @(negedge mgmt_clock) begin
    if (bit_cnt == 6'h2F) phy_oe <= mdio_seen[12:11] == 2'b10;
    else if (bit_cnt == 6'h00) phy_oe <= 1'b0;
    phy_out <= bit_cnt == 6'h2F ? 1'b0 : READ_VAL[6'h3F - bit_cnt];
  end
endmodule

// ==== verification/rrm_master_port_tb.sv ====
`timescale 1ns/1ns
module rrm_master_port_tb
  import rrm_pkg::*;
();
  logic clock = 1'b0;
  logic hw_reset_n = 1'b0;
  logic host_width_select = 1'b1;
  logic [10:0] host_addr = 11'h000;
  logic [31:0] host_data_in = 32'h0;
  logic [31:0] mgmt_command = 32'h0;
  logic [31:0] host_data_oe, last_oe;
  logic [31:0] host_data_out, last_data;
  rrm_host_strobe_t hs = 3'b111;
  logic host_stall_n, link_clock, tx_enable, rx_valid, rx_error, mgmt_clock, mgmt_data_in;
  logic mgmt_data_out, mgmt_data_oe, mgmt_busy, rx_frame_bad;
  logic mgmt_start = 1'b0;
  logic [3:0] tx_nibble, rx_nibble;
  logic [15:0] mgmt_read_data;
  logic [1:0] err_mode = 2'h0;
  int fails = 0;
  int n_compared = 0;
  always #4 clock = ~clock;
  rrm_master_port DUT (
    .clock, .hw_reset_n, .op_select_hi(1'b0), .op_select_lo(1'b0), .host_width_select,
    .host_addr, .host_data_in, .host_data_out, .host_data_oe, .host_select_n(hs.sel),
    .host_read_n(hs.rd), .host_write_n(hs.wr), .host_stall_n, .tx_clock(link_clock),
    .tx_nibble, .tx_enable, .rx_clock(link_clock), .rx_nibble, .rx_valid, .rx_error,
    .mgmt_clock, .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe, .mgmt_command, .mgmt_start,
    .mgmt_read_data, .mgmt_busy, .master_mode(), .rx_frame_bad
  );
  rrm_phy_model phy (
    .link_clock, .tx_nibble, .tx_enable, .rx_nibble, .rx_valid, .rx_error, .err_mode,
    .mgmt_clock, .mgmt_data_out, .mgmt_data_oe, .mgmt_data_in
  );
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes stay put until wait is seen high at an edge
  task automatic host_cycle(input logic wr, input logic [10:0] a, input logic [31:0] d,
    input logic sel);
    int n;
    n = 0;
    @(posedge clock);
    hs <= {!sel, wr, !wr};
    host_addr <= a;
    host_data_in <= d;
    while ((host_stall_n !== 1'b1 || n < 2) && n < 20) @(posedge clock) n++;
    if (n == 20) check(32'h0, 32'h1);
    last_oe = host_data_oe;
    last_data = host_data_out;
    hs <= 3'b111;
    repeat (2) @(posedge clock);
  endtask
  task automatic frame_end();
    int n;
    n = 0;
    while (tx_enable !== 1'b1 && n < 4000) @(posedge clock) n++;
    while (tx_enable !== 1'b0 && n < 4000) @(posedge clock) n++;
    if (n == 4000) check(32'h0, 32'h1);
  endtask
  function automatic logic [31:0] nib_word(input int base);
    logic [31:0] w;
    for (int k = 0; k < 8; k++) w[4*k +: 4] = phy.frame[base + k];
    return w;
  endfunction
  task automatic t_reset();
    repeat (16) @(posedge clock);
    check({28'h0, host_stall_n, tx_enable, mgmt_clock, mgmt_data_oe}, 32'h8);
    check(host_data_oe, 32'h0);
  endtask
  // Every word of each bank filled within one frame period, so no nibble is unknown
  task automatic t_host();
    for (int b = 0; b < 2; b++) begin
      frame_end();
      for (int w = 0; w < 128; w++) begin
        host_cycle(1'b1, 11'(w * 4),
          w == 0 ? 32'hA1B2C3D4 : w == 127 ? 32'h0F1E2D3C : {4{8'(w)}}, 1'b1);
      end
    end
    frame_end();
    frame_end();
    check(nib_word(16), 32'hA1B2C3D4);
    check(nib_word(1032), 32'h0F1E2D3C);
    host_cycle(1'b0, 11'h404, 32'h0, 1'b1);
    check(last_oe, 32'hFFFFFFFF);
    check(last_data, 32'h01010101);
    host_cycle(1'b0, 11'h404, 32'h0, 1'b0);
    check(last_oe, 32'h0);
    host_width_select <= 1'b0;
    host_cycle(1'b0, 11'h406, 32'h0, 1'b1);
    check(last_oe, 32'h0000FFFF);
    check(last_data, 32'h00000101);
    host_width_select <= 1'b1;
  endtask
  task automatic t_rx();
    logic [1:0] modes [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    foreach (modes[i]) begin
      frame_end();
      err_mode <= modes[i];
      frame_end();
      repeat (40) @(posedge clock);
      check({31'h0, rx_frame_bad}, {31'h0, modes[i] != 2'h0});
    end
  endtask
  task automatic mdio_op(input logic [31:0] c);
    int n;
    n = 0;
    @(posedge clock);
    mgmt_command <= c;
    mgmt_start <= 1'b1;
    while (mgmt_busy !== 1'b1 && n < 200) @(posedge clock) n++;
    mgmt_start <= 1'b0;
    while (mgmt_busy !== 1'b0 && n < 5000) @(posedge clock) n++;
    if (n == 5000) check(32'h0, 32'h1);
  endtask
  task automatic t_mdio();
    mdio_op(32'h5A32BEEF);
    check(phy.mdio_seen, 32'h5A32BEEF);
    mdio_op(32'h6A320000);
    check({16'h0, mgmt_read_data}, 32'h0000A5C3);
  endtask
  initial begin
    #600000;
    fails++;
    tally_and_finish();
  end
  initial begin
    t_reset();
    hw_reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    t_host();
    t_rx();
    t_mdio();
    tally_and_finish();
  end
endmodule
bind rrm_master_port rrm_master_port_monitor u_mon (
  .clock, .hw_reset_n, .op_select_hi, .op_select_lo, .host_width_select, .host_select_n,
  .host_read_n, .host_data_oe, .host_stall_n, .tx_clock, .tx_nibble, .tx_enable,
  .mgmt_clock, .mgmt_data_oe, .master_mode
);
